// ===== verilog/sesc_pkg.sv
// Constants, types and decode functions for the symbol error scaling block
// Behaviour
// - Left-shift sampling error by the shift field
// - Shift codes give x2, x4, x8, x16
// - Overflowing shifted error saturates, never wraps
// - Order field picks thresholds for I and Q
// - Order codes select 2, 4, 8, 16-ary
// - End-of-symbol samples sliced into expected symbols
// - Thresholds split minus one to one equally
package sesc_pkg;

  // Destination address of the symbol loop configuration word
  localparam logic [7:0] SYMBOL_LOOP_CONFIG_ADDR = 8'h0E;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Field positions inside the configuration word
  localparam int SHIFT_MSB = 12;
  localparam int SHIFT_LSB = 11;
  localparam int ORDER_MSB = 10;
  localparam int ORDER_LSB = 9;

  // Datapath widths; samples span -1.0 .. +1.0 at full scale
  localparam int ERR_W = 16;
  localparam int SAMP_W = 10;
  localparam int SHIFT_MAX = 4;

  // Saturation limits of the scaled error
  localparam logic signed [ERR_W-1:0] ERR_MAX = 16'sh7FFF;
  localparam logic signed [ERR_W-1:0] ERR_MIN = 16'sh8000;

  // Sample levels of +0.5 and +0.75, used by the decision checks
  localparam logic signed [SAMP_W-1:0] SAMP_HALF = 10'sh100;
  localparam logic signed [SAMP_W-1:0] SAMP_3Q = 10'sh180;

  // Shift gain codes
  typedef enum logic [1:0] {GAIN_X2, GAIN_X4, GAIN_X8, GAIN_X16} sesc_gain_type;

  // Modulation order codes
  typedef enum logic [1:0] {ORD_2, ORD_4, ORD_8, ORD_16} sesc_order_type;

  // Reset values of the two fields
  localparam sesc_gain_type GAIN_RESET = GAIN_X2;
  localparam sesc_order_type ORDER_RESET = ORD_2;

  // Places of left shift for a gain code: one to four
  function automatic logic [2:0] sesc_shift_places(input sesc_gain_type g);
    sesc_shift_places = {1'b0, g} + 3'h1;
  endfunction

  // Bits of symbol index for an order code: one to four
  function automatic logic [2:0] sesc_level_bits(input sesc_order_type o);
    sesc_level_bits = {1'b0, o} + 3'h1;
  endfunction

endpackage

// ===== verilog/sesc_decide.sv
// Symbol decision slicer for one rail
`timescale 1ns/10ps
`default_nettype none
module sesc_decide (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic load,
  input wire sesc_pkg::sesc_order_type order,
  input wire logic signed [sesc_pkg::SAMP_W-1:0] sample,
  output logic signed [sesc_pkg::SAMP_W-1:0] expected_reg
);

  // Sample moved to an unsigned scale, 0 standing for -1.0
  logic [sesc_pkg::SAMP_W-1:0] offset;
  // Index bits for the selected order
  logic [2:0] nbits;
  // Right shift that leaves only the region index
  logic [3:0] rshift;
  // Region index, zero for the most negative slot
  logic [sesc_pkg::SAMP_W-1:0] region;
  // Region centre on the unsigned scale
  logic [sesc_pkg::SAMP_W-1:0] centre;
  logic signed [sesc_pkg::SAMP_W-1:0] expected_next;

  // Equal slots: the top index bits of the offset sample pick the slot,
  // so thresholds sit at every 2/N step from -1.0 with no comparators
  always_comb begin
    offset = {~sample[sesc_pkg::SAMP_W-1], sample[sesc_pkg::SAMP_W-2:0]};
    nbits = sesc_pkg::sesc_level_bits(order);
    rshift = 4'(sesc_pkg::SAMP_W) - {1'b0, nbits};
    region = offset >> rshift;
    // Slot centre is (2j+1) half-slots above -1.0
    centre = {region[sesc_pkg::SAMP_W-2:0], 1'b1} << (rshift - 4'h1);
    expected_next = {~centre[sesc_pkg::SAMP_W-1], centre[sesc_pkg::SAMP_W-2:0]};
  end

  // Expected symbol register; a sample on a threshold goes to the upper slot
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      expected_reg <= '0;
    end else if (ce && load) begin
      expected_reg <= expected_next;
    end
  end

  // Two-ary slicing gives +/-0.5 by the sign of the sample
  two_ary_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && load && order == sesc_pkg::ORD_2 |=>
      expected_reg == ($past(sample[sesc_pkg::SAMP_W-1]) ?
                       -sesc_pkg::SAMP_HALF : sesc_pkg::SAMP_HALF))
    else $error("two-ary decision wrong");

  // Four-ary: at or above +0.5 the top level +0.75 results
  four_ary_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && load && order == sesc_pkg::ORD_4 && sample >= sesc_pkg::SAMP_HALF |=>
      expected_reg == sesc_pkg::SAMP_3Q)
    else $error("four-ary top decision wrong");

  // Between 0 and +0.5 four-ary gives +0.25
  four_mid_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && load && order == sesc_pkg::ORD_4 && sample >= 0
      && sample < sesc_pkg::SAMP_HALF |=>
      expected_reg == (sesc_pkg::SAMP_HALF >>> 1))
    else $error("four-ary inner decision wrong");

endmodule
`default_nettype wire

// ===== verilog/sesc_top.sv
// Symbol error scaling: config word, saturating error shifter, I/Q slicers
`timescale 1ns/10ps
`default_nettype none
module sesc_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic cfg_wr,
  input wire logic [sesc_pkg::ADDR_W-1:0] cfg_addr,
  input wire logic [sesc_pkg::DATA_W-1:0] cfg_wdata,
  input wire logic err_valid,
  input wire logic signed [sesc_pkg::ERR_W-1:0] err_in,
  input wire logic sym_valid,
  input wire logic signed [sesc_pkg::SAMP_W-1:0] sym_i,
  input wire logic signed [sesc_pkg::SAMP_W-1:0] sym_q,
  output logic err_out_valid,
  output logic signed [sesc_pkg::ERR_W-1:0] err_out,
  output logic err_sat,
  output logic exp_valid,
  output logic signed [sesc_pkg::SAMP_W-1:0] exp_i,
  output logic signed [sesc_pkg::SAMP_W-1:0] exp_q,
  output logic [1:0] cfg_shift,
  output logic [1:0] cfg_order
);

  localparam int EXT_W = sesc_pkg::ERR_W + sesc_pkg::SHIFT_MAX;

  // Stored shift gain code
  sesc_pkg::sesc_gain_type gain_reg;
  // Stored modulation order code
  sesc_pkg::sesc_order_type order_reg;
  // Write strobe aimed at this block's address
  logic cfg_hit;

  // Sign-extended error, wide enough for a four-place shift
  logic [EXT_W-1:0] err_ext;
  // Error after the shift, before saturation
  logic [EXT_W-1:0] err_shifted;
  // Places of shift for the current code
  logic [2:0] places;
  // Shifted error no longer fits the output width
  logic err_ovf;
  // Value chosen for the output register
  logic signed [sesc_pkg::ERR_W-1:0] err_next;

  // Slicer per rail; index 0 is I, index 1 is Q
  logic signed [sesc_pkg::SAMP_W-1:0] rail_sample [2];
  logic signed [sesc_pkg::SAMP_W-1:0] rail_expected [2];

  // Address decode of the write-only configuration word
  always_comb begin
    cfg_hit = cfg_wr && (cfg_addr == sesc_pkg::SYMBOL_LOOP_CONFIG_ADDR);
  end

  // Configuration capture; reserved and unused bits are not stored, so a
  // nonzero reserved write has no effect here, but software keeps them zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gain_reg <= sesc_pkg::GAIN_RESET;
      order_reg <= sesc_pkg::ORDER_RESET;
    end else if (ce && cfg_hit) begin
      gain_reg <= sesc_pkg::sesc_gain_type'(
        cfg_wdata[sesc_pkg::SHIFT_MSB:sesc_pkg::SHIFT_LSB]);
      order_reg <= sesc_pkg::sesc_order_type'(
        cfg_wdata[sesc_pkg::ORDER_MSB:sesc_pkg::ORDER_LSB]);
    end
  end

  // Field readback so the host logic sees what is in force
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_shift <= sesc_pkg::GAIN_RESET;
      cfg_order <= sesc_pkg::ORDER_RESET;
    end else if (ce && cfg_hit) begin
      cfg_shift <= cfg_wdata[sesc_pkg::SHIFT_MSB:sesc_pkg::SHIFT_LSB];
      cfg_order <= cfg_wdata[sesc_pkg::ORDER_MSB:sesc_pkg::ORDER_LSB];
    end
  end

  // Shift and overflow test; extending first keeps the sign bits visible,
  // so overflow is any disagreement among the output sign bit and the bits above it
  always_comb begin
    places = sesc_pkg::sesc_shift_places(gain_reg);
    err_ext = {{sesc_pkg::SHIFT_MAX{err_in[sesc_pkg::ERR_W-1]}}, err_in};
    err_shifted = err_ext << places;
    err_ovf = !(&err_shifted[EXT_W-1:sesc_pkg::ERR_W-1])
      && (|err_shifted[EXT_W-1:sesc_pkg::ERR_W-1]);
    if (err_ovf) begin
      // Clamp on the side of the input sign
      err_next = err_in[sesc_pkg::ERR_W-1] ? sesc_pkg::ERR_MIN : sesc_pkg::ERR_MAX;
    end else begin
      err_next = err_shifted[sesc_pkg::ERR_W-1:0];
    end
  end

  // Scaled error register, one cycle behind the input strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_out <= '0;
      err_sat <= 1'b0;
    end else if (ce && err_valid) begin
      err_out <= err_next;
      err_sat <= err_ovf;
    end
  end

  // Error strobe; a frozen clock enable holds it as it stands
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      err_out_valid <= 1'b0;
    end else if (ce) begin
      err_out_valid <= err_valid;
    end
  end

  // Symbol decision strobe for both rails
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      exp_valid <= 1'b0;
    end else if (ce) begin
      exp_valid <= sym_valid;
    end
  end

  // Both rails share one threshold set, so one order drives both slicers
  always_comb begin
    rail_sample[0] = sym_i;
    rail_sample[1] = sym_q;
  end

  // One slicer per rail; a change of order reaches both rails at the same
  // edge, so I and Q never decide against different threshold sets
  generate
    for (genvar r = 0; r < 2; r++) begin : g_rail
      sesc_decide u_decide (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ce(ce),
        .load(sym_valid),
        .order(order_reg),
        .sample(rail_sample[r]),
        .expected_reg(rail_expected[r])
      );
    end
  endgenerate

  // Slicer registers feed the outputs with no extra logic
  always_comb begin
    exp_i = rail_expected[0];
    exp_q = rail_expected[1];
  end

  // Write of the configuration word, then the fields in force
  sequence cfg_write_s;
    ce && cfg_hit;
  endsequence

  sequence fields_loaded_s;
    gain_reg == $past(cfg_wdata[sesc_pkg::SHIFT_MSB:sesc_pkg::SHIFT_LSB])
      && order_reg == $past(cfg_wdata[sesc_pkg::ORDER_MSB:sesc_pkg::ORDER_LSB]);
  endsequence

  cfg_load_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cfg_write_s |=> fields_loaded_s)
    else $error("config fields not loaded");

  // Other addresses leave the fields alone
  cfg_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(ce && cfg_hit) |=> $stable(gain_reg) && $stable(order_reg))
    else $error("config changed without a write");

  // In range, the output is the input times 2, 4, 8 or 16
  shift_gain_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && err_valid && !err_ovf |=>
      int'(err_out) == int'($past(err_in)) * (2 << $past(gain_reg)))
    else $error("scaled error gain wrong");

  // A saturated result is an extreme with the input's sign
  sat_clamp_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && err_valid && err_ovf |=>
      err_sat && err_out == ($past(err_in[sesc_pkg::ERR_W-1]) ?
                             sesc_pkg::ERR_MIN : sesc_pkg::ERR_MAX))
    else $error("saturation value wrong");

  // Large positive inputs at x16 always saturate instead of wrapping
  sat_x16_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && err_valid && gain_reg == sesc_pkg::GAIN_X16 && err_in > 16'sh07FF |=>
      err_out == sesc_pkg::ERR_MAX)
    else $error("x16 overflow not saturated");

  // Output strobes follow inputs by exactly one enabled cycle; each stream
  // is watched on its own, since the two seldom strobe together
  strobe_lag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ce && sym_valid |=> exp_valid)
      and (ce && err_valid |=> err_out_valid))
    else $error("output strobe missing");

  // Clock enable low freezes the scaled error, both decisions and both strobes
  ce_freeze_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !ce |=> $stable(err_out) && $stable(exp_i) && $stable(exp_q)
      && $stable(err_out_valid) && $stable(exp_valid))
    else $error("state moved while frozen");

  // Error strobe lasts a single enabled cycle per term
  err_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && !err_valid |=> !err_out_valid)
    else $error("error strobe stretched");

  // Decision strobe lasts a single enabled cycle per sample pair
  exp_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && !sym_valid |=> !exp_valid)
    else $error("decision strobe stretched");

  // Decisions hold between taken samples
  exp_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(ce && sym_valid) |=> $stable(exp_i) && $stable(exp_q))
    else $error("decision changed without a sample");

  // A nonzero error keeps its sign through shift and clamp
  sign_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && err_valid && err_in != '0 |=>
      err_out[sesc_pkg::ERR_W-1] == $past(err_in[sesc_pkg::ERR_W-1]))
    else $error("scaled error changed sign");

  // In-range results leave the saturation flag clear
  sat_flag_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ce && err_valid && !err_ovf |=> !err_sat)
    else $error("saturation flagged in range");

endmodule
`default_nettype wire

// ===== tb/sesc_feed.sv
// Upstream feed model: sampling error terms and end-of-symbol I/Q samples
`timescale 1ns/10ps
`default_nettype none
module sesc_feed (
  input wire logic clk_sys,
  output logic err_valid,
  output logic signed [sesc_pkg::ERR_W-1:0] err_in,
  output logic sym_valid,
  output logic signed [sesc_pkg::SAMP_W-1:0] sym_i,
  output logic signed [sesc_pkg::SAMP_W-1:0] sym_q
);
  // Quiet lines at time zero
  initial begin
    err_valid = 1'b0;
    err_in = 16'h0000;
    sym_valid = 1'b0;
    sym_i = 10'h000;
    sym_q = 10'h000;
  end

  // One error term for one cycle; afterwards the bus shows the inverse,
  // so a design that samples late picks up visibly wrong data
  task automatic send_err(input logic signed [sesc_pkg::ERR_W-1:0] v);
    @(posedge clk_sys);
    err_valid <= 1'b1;
    err_in <= v;
    @(posedge clk_sys);
    err_valid <= 1'b0;
    err_in <= ~v;
  endtask

  // One I/Q sample pair, taken together, then released as inverses
  task automatic send_sym(input logic signed [sesc_pkg::SAMP_W-1:0] i,
                          input logic signed [sesc_pkg::SAMP_W-1:0] q);
    @(posedge clk_sys);
    sym_valid <= 1'b1;
    sym_i <= i;
    sym_q <= q;
    @(posedge clk_sys);
    sym_valid <= 1'b0;
    sym_i <= ~i;
    sym_q <= ~q;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the symbol error scaling block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_wr = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  // Clock enable, lowered once to show that the configuration, the scaled error and its strobe freeze
  logic ce = 1'b1;
  logic err_valid, sym_valid, err_out_valid, err_sat, exp_valid;
  logic signed [15:0] err_in, err_out;
  logic signed [9:0] sym_i, sym_q, exp_i, exp_q;
  logic [1:0] cfg_shift, cfg_order;
  int n_mismatch = 0;
  int tests_run = 0;
  // Error terms around the x2 and x16 saturation boundaries
  logic [15:0] errs [8] = '{16'h0001, 16'hFFFF, 16'h07FF, 16'hF800,
                            16'h3FFF, 16'hC000, 16'h7FFF, 16'h8000};
  // Samples at range ends and on or beside thresholds
  logic [9:0] samps [8] = '{10'h200, 10'h1FF, 10'h000, 10'h3FF,
                            10'h100, 10'h0FF, 10'h300, 10'h080};

  // 100 ns clock
  always #50 clk_sys = ~clk_sys;

  sesc_feed u_sesc_feed (.clk_sys(clk_sys), .err_valid(err_valid), .err_in(err_in),
    .sym_valid(sym_valid), .sym_i(sym_i), .sym_q(sym_q));

  sesc_top u_sesc_top (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .err_valid(err_valid), .err_in(err_in),
    .sym_valid(sym_valid), .sym_i(sym_i), .sym_q(sym_q), .err_out_valid(err_out_valid),
    .err_out(err_out), .err_sat(err_sat), .exp_valid(exp_valid), .exp_i(exp_i),
    .exp_q(exp_q), .cfg_shift(cfg_shift), .cfg_order(cfg_order));

  // Compare and count; case inequality so unknowns never match
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected scaled error, clamped to the signed extremes
  function automatic logic [16:0] scale(input logic signed [15:0] v, input int code);
    int p;
    p = int'(v) * (2 << code);
    if (p > 32767) return {1'b1, 16'h7FFF};
    if (p < -32768) return {1'b1, 16'h8000};
    return {1'b0, p[15:0]};
  endfunction

  // Expected slot centre for 2^(code+1) equal slots; a tie goes upward
  function automatic logic [9:0] slice(input logic signed [9:0] s, input int code);
    int n, j, c;
    n = 2 << code;
    j = ((int'(s) + 512) * n) / 1024;
    if (j > n - 1) j = n - 1;
    c = -512 + (2 * j + 1) * (512 / n);
    return c[9:0];
  endfunction

  // Configuration write: one strobe cycle, then released
  task automatic wr_cfg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
    cfg_addr <= ~a;
    #1;
  endtask

  // Counts, verdict, end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog well beyond the roughly 160 cycles the tests need
  initial begin
    #1000000;
    n_mismatch++;
    give_verdict();
  end

  // Main sequence
  initial begin
    logic [16:0] e;
    logic [9:0] s;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    check({14'h0000, cfg_shift}, 16'h0000);
    check({14'h0000, cfg_order}, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      // Shift and order set apart so swapped fields show up
      wr_cfg(8'h0E, {19'h00000, k[1:0], 2'(3 - k), 9'h000});
      check({14'h0000, cfg_shift}, 16'(k));
      check({14'h0000, cfg_order}, 16'(3 - k));
      for (int m = 0; m < 8; m++) begin
        u_sesc_feed.send_err(errs[m]);
        #1;
        e = scale(errs[m], k);
        check({15'h0000, err_out_valid}, 16'h0001);
        check(err_out, e[15:0]);
        check({15'h0000, err_sat}, {15'h0000, e[16]});
        u_sesc_feed.send_sym(samps[m], ~samps[m]);
        #1;
        s = slice(samps[m], 3 - k);
        check({15'h0000, exp_valid}, 16'h0001);
        check({6'h00, exp_i}, {6'h00, s});
        check({6'h00, exp_q}, {6'h00, slice(~samps[m], 3 - k)});
        check({15'h0000, err_out_valid}, 16'h0000);
      end
    end
    // Recommended pairing, then a write elsewhere must leave it alone
    wr_cfg(8'h0E, {19'h00000, 2'h1, 2'h1, 9'h000});
    wr_cfg(8'h0F, 32'hFFFF_FFFF);
    check({12'h000, cfg_shift, cfg_order}, 16'h0005);
    u_sesc_feed.send_err(16'hE000);
    #1;
    check(err_out, 16'h8000);
    // Clock enable low: a write and an error term are both ignored
    @(posedge clk_sys);
    ce <= 1'b0;
    wr_cfg(8'h0E, 32'h0000_1E00);
    u_sesc_feed.send_err(16'h0100);
    #1;
    check({12'h000, cfg_shift, cfg_order}, 16'h0005);
    check(err_out, 16'h8000);
    check({15'h0000, err_out_valid}, 16'h0000);
    // Enabled again, the x4 gain is still in force
    @(posedge clk_sys);
    ce <= 1'b1;
    u_sesc_feed.send_err(16'h0100);
    #1;
    check(err_out, 16'h0400);
    check({15'h0000, err_sat}, 16'h0000);
    give_verdict();
  end
endmodule
`default_nettype wire
